//--- core/hkr_host.sv
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "hkr_params.svh"
module hkr_host
    import hkr_pkg::*;
#(
    parameter int TRIM_CYC = `HKR_TRIM_CYC,
    parameter int REV_MIN  = `HKR_REV_MIN_CYC,
    parameter int REV_MAX  = `HKR_REV_MAX_CYC,
    parameter int GAP_CYC  = `HKR_GAP_CYC,
    parameter int RING_MIN = `HKR_RING_PULSES
)
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // software register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    // device pins
    output logic             hook_control_n_o,
    input  wire logic        ring_detect_full_n_i,
    // caller identity window for the receive datapath
    output logic             caller_identity_win_o
);
    localparam int CW = 32;

    logic          full_lvl;
    logic          full_prev_q, full_prev_d;
    logic [1:0]    ctrl_q, ctrl_d;
    hkr_hook_t     st_q, st_d;
    logic [CW-1:0] tmr_q, tmr_d;     // trim hold timer
    logic [CW-1:0] low_q, low_d;     // current low pulse width
    logic [CW-1:0] gap_q, gap_d;     // time since last pulse
    logic [7:0]    pcnt_q, pcnt_d;   // pulses in current burst
    logic [7:0]    bcnt_q, bcnt_d;   // completed bursts
    logic          ringing_q, ringing_d;
    logic          cid_q, cid_d;
    logic          trim_q, trim_d;
    logic [2:0]    evt_q, evt_d;
    logic          hook_n_q, hook_n_d;
    logic [31:0]   rdata_q, rdata_d;
    logic          fall, rise, onhook, short_ok, alone;

    // pin conditioning before any edge or width logic
    hkr_sync u_sync_full
    (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (ring_detect_full_n_i),
        .level_o   (full_lvl)
    );

    assign fall   = full_prev_q & ~full_lvl;
    assign rise   = ~full_prev_q & full_lvl;
    assign onhook = hook_n_q;
    // a lone short pulse (no ringing around it) is a reversal
    assign short_ok = (low_q >= CW'(REV_MIN)) && (low_q <= CW'(REV_MAX));
    assign alone    = ~ringing_q && (pcnt_q == 8'h00);

    // hook sequencing: forced on-hook hold after reset loads trim
    always_comb
    begin
        st_d     = st_q;
        tmr_d    = tmr_q;
        trim_d   = trim_q;
        hook_n_d = 1'b1;
        unique case (st_q)
            HKR_TRIM:
            begin
                tmr_d = tmr_q + CW'(1);
                if (tmr_q >= CW'(TRIM_CYC - 1))
                begin
                    trim_d = 1'b1;
                    st_d   = HKR_IDLE;
                end
            end
            HKR_IDLE:
            begin
                if (ctrl_q[`HKR_CTRL_OFFHOOK])
                begin
                    st_d = HKR_BUSY;
                end
            end
            HKR_BUSY:
            begin
                hook_n_d = 1'b0;
                if (!ctrl_q[`HKR_CTRL_OFFHOOK])
                begin
                    st_d = HKR_IDLE;
                end
            end
            default:
            begin
                st_d = HKR_TRIM;
            end
        endcase
    end

    // ring qualification; detects are ignored off-hook since the device
    // disables them there and a stuck level must not read as ringing
    always_comb
    begin
        full_prev_d = full_lvl;
        low_d       = low_q;
        gap_d       = gap_q;
        pcnt_d      = pcnt_q;
        bcnt_d      = bcnt_q;
        ringing_d   = ringing_q;
        cid_d       = cid_q;
        evt_d       = evt_q;
        if (!onhook)
        begin
            low_d     = '0;
            gap_d     = '0;
            pcnt_d    = 8'h00;
            ringing_d = 1'b0;
            cid_d     = 1'b0;
            bcnt_d    = 8'h00;
        end
        else
        begin
            if (!full_lvl)
            begin
                low_d = low_q + CW'(1);
                gap_d = '0;
            end
            else if (gap_q < CW'(GAP_CYC))
            begin
                gap_d = gap_q + CW'(1);
            end
            if (fall)
            begin
                low_d = CW'(1);
            end
            if (rise)
            begin
                if (short_ok && alone)
                begin
                    evt_d[`HKR_EV_REVERSAL] = 1'b1;
                end
                else if (pcnt_q != 8'hFF)
                begin
                    pcnt_d = pcnt_q + 8'h01;
                end
            end
            if (pcnt_q >= 8'(RING_MIN) && !ringing_q)
            begin
                ringing_d            = 1'b1;
                evt_d[`HKR_EV_RING] = 1'b1;
            end
            if (full_lvl && gap_q == CW'(GAP_CYC - 1))
            begin
                pcnt_d = 8'h00;
                if (ringing_q)
                begin
                    ringing_d = 1'b0;
                    bcnt_d    = bcnt_q + 8'h01;
                    evt_d[`HKR_EV_BURSTEND] = 1'b1;
                end
            end
            // caller window: early mode always, else after first burst
            cid_d = ctrl_q[`HKR_CTRL_CIDEARLY] ? 1'b1
                  : (bcnt_q != 8'h00);
        end
        // write-one-to-clear; a set in the same cycle wins only on a bit that was clear
        if (wr_i && addr_i == `HKR_ADDR_EVT)
        begin
            evt_d = evt_d & ~(wdata_i[2:0] & ~(evt_d ^ evt_q));
        end
    end

    // register port: control write and one-cycle-late read data
    always_comb
    begin
        ctrl_d  = ctrl_q;
        rdata_d = 32'h0;
        if (wr_i && addr_i == `HKR_ADDR_CTRL)
        begin
            ctrl_d = wdata_i[1:0];
        end
        if (rd_i)
        begin
            unique case (addr_i)
                `HKR_ADDR_CTRL: rdata_d = {30'h0, ctrl_q};
                `HKR_ADDR_STAT: rdata_d = {27'h0, full_lvl, cid_q,
                                           ringing_q, trim_q, ~hook_n_q};
                `HKR_ADDR_EVT:  rdata_d = {29'h0, evt_q};
                `HKR_ADDR_CNT:  rdata_d = {16'h0, bcnt_q, pcnt_q};
                default:        rdata_d = 32'h0;
            endcase
        end
    end

    // state registers
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_q        <= HKR_TRIM;
            tmr_q       <= '0;
            trim_q      <= 1'b0;
            hook_n_q    <= 1'b1;
            full_prev_q <= 1'b1;
            low_q       <= '0;
            gap_q       <= '0;
            pcnt_q      <= 8'h00;
            bcnt_q      <= 8'h00;
            ringing_q   <= 1'b0;
            cid_q       <= 1'b0;
            evt_q       <= 3'h0;
            ctrl_q      <= 2'h0;
            rdata_q     <= 32'h0;
        end
        else
        begin
            st_q        <= st_d;
            tmr_q       <= tmr_d;
            trim_q      <= trim_d;
            hook_n_q    <= hook_n_d;
            full_prev_q <= full_prev_d;
            low_q       <= low_d;
            gap_q       <= gap_d;
            pcnt_q      <= pcnt_d;
            bcnt_q      <= bcnt_d;
            ringing_q   <= ringing_d;
            cid_q       <= cid_d;
            evt_q       <= evt_d;
            ctrl_q      <= ctrl_d;
            rdata_q     <= rdata_d;
        end
    end

    assign rdata_o               = rdata_q;
    assign hook_control_n_o      = hook_n_q;
    assign caller_identity_win_o = cid_q;

    // hook never goes low before trim hold has finished
    a_trim_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !trim_q |-> hook_control_n_o)
        else $error("hook went low before trim hold");

    // off-hook request reaches the pin two edges later
    a_offhook_go: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        (st_q == HKR_IDLE && ctrl_q[`HKR_CTRL_OFFHOOK])
        |=> ##1 !hook_control_n_o)
        else $error("off-hook request not honoured");

    // outside the off-hook state the pin is always back high next cycle
    a_onhook_keep: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        st_q != HKR_BUSY |=> hook_control_n_o)
        else $error("hook low without off-hook state");

    // no ringing status while off-hook
    a_offhook_quiet: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        !hook_control_n_o |=> !ringing_q && !cid_q)
        else $error("ringing state kept while off-hook");

    // reversal event only from a short pulse ending on a rise
    a_rev_cause: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        $rose(evt_q[`HKR_EV_REVERSAL])
        |-> $past(short_ok) && $past(rise))
        else $error("reversal flagged without short pulse");

    // ringing only after enough pulses
    a_ring_qual: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        $rose(ringing_q) |-> $past(pcnt_q) >= 8'(RING_MIN))
        else $error("ringing qualified too early");
endmodule

//--- core/hkr_params.svh
`ifndef HKR_PARAMS_SVH
`define HKR_PARAMS_SVH

// clock and timing
`define HKR_CLK_MHZ          125
`define HKR_TRIM_MS          50
`define HKR_TRIM_CYC         ((`HKR_TRIM_MS) * 1000 * (`HKR_CLK_MHZ))
`define HKR_REV_US           1000
`define HKR_REV_MIN_US       500
`define HKR_REV_MAX_US       2000
`define HKR_REV_MIN_CYC      ((`HKR_REV_MIN_US) * (`HKR_CLK_MHZ))
`define HKR_REV_MAX_CYC      ((`HKR_REV_MAX_US) * (`HKR_CLK_MHZ))
`define HKR_GAP_MS           100
`define HKR_GAP_CYC          ((`HKR_GAP_MS) * 1000 * (`HKR_CLK_MHZ))
`define HKR_RING_PULSES      4

// register map (word addresses)
`define HKR_ADDR_CTRL        4'h0
`define HKR_ADDR_STAT        4'h1
`define HKR_ADDR_EVT         4'h2
`define HKR_ADDR_CNT         4'h3

// control fields
`define HKR_CTRL_OFFHOOK     0
`define HKR_CTRL_CIDEARLY    1

// status fields
`define HKR_ST_OFFHOOK       0
`define HKR_ST_TRIMDONE      1
`define HKR_ST_RINGING       2
`define HKR_ST_CIDWIN        3
`define HKR_ST_RAWFULL       4

// event fields
`define HKR_EV_RING          0
`define HKR_EV_BURSTEND      1
`define HKR_EV_REVERSAL      2

`endif

//--- core/hkr_pkg.sv
package hkr_pkg;
    typedef enum logic [1:0]
    {
        HKR_TRIM = 2'b00,
        HKR_IDLE = 2'b01,
        HKR_BUSY = 2'b11
    } hkr_hook_t;
endpackage

//--- core/hkr_sync.sv
`timescale 1ns/1ps
// three-stage input conditioner; a change counts once stages two and three
// agree, so the first stage never feeds anything but the second
module hkr_sync
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    // raw pin and conditioned level
    input  wire logic pin_i,
    output logic      level_o
);
    logic [2:0] sh_q;
    logic [2:0] sh_d;
    logic       lvl_q;
    logic       lvl_d;

    // shift in, accept only stable pairs; idle line is high
    always_comb
    begin
        sh_d  = {sh_q[1:0], pin_i};
        lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sh_q  <= 3'h7;
            lvl_q <= 1'b1;
        end
        else
        begin
            sh_q  <= sh_d;
            lvl_q <= lvl_d;
        end
    end

    assign level_o = lvl_q;
endmodule

//--- verification/hkr_line_model.sv
`timescale 1ns/1ps
// behavioural line device: full-wave ring detect driven from bench commands
module hkr_line_model
#(
    parameter int LOW_CYC = 16,
    parameter int HI_CYC  = 3,
    parameter int REV_LEN = 8
)
(
    // clock used only to pace the waveform
    input  wire logic ref_clk_i,
    // hook pin from the host
    input  wire logic hook_control_n_i,
    // bench commands: ringing present, reversal pulse
    input  wire logic ring_on_i,
    input  wire logic rev_i,
    // full-wave and half-wave detect outputs, both idle high
    output logic      ring_detect_full_n_o,
    output logic      ring_detect_half_n_o
);
    int   phase_q = 0;
    int   rev_q   = 0;
    logic half_q  = 1'b0;

    initial ring_detect_full_n_o = 1'b1;
    initial ring_detect_half_n_o = 1'b1;

    // one process: waveform must restart cleanly on every hook change
    always @(posedge ref_clk_i)
    begin
        if (!hook_control_n_i)
        begin
            // off-hook: detector disabled, snoop path gone
            ring_detect_full_n_o <= 1'b1;
            ring_detect_half_n_o <= 1'b1;
            phase_q              <= 0;
            rev_q                <= 0;
            half_q               <= 1'b0;
        end
        else if (rev_i || rev_q != 0)
        begin
            // lone low pulse on battery reversal, full-wave only
            ring_detect_full_n_o <= 1'b0;
            ring_detect_half_n_o <= 1'b1;
            rev_q                <= rev_i ? REV_LEN - 1 : rev_q - 1;
        end
        else if (ring_on_i)
        begin
            // snoop active on-hook; low most of each half, brief high
            ring_detect_full_n_o <= (phase_q >= LOW_CYC);
            // half-wave: low in the first half of each cycle only
            ring_detect_half_n_o <= half_q || (phase_q >= LOW_CYC);
            phase_q <= (phase_q == LOW_CYC + HI_CYC - 1) ? 0 : phase_q + 1;
            if (phase_q == LOW_CYC + HI_CYC - 1)
            begin
                half_q <= ~half_q;
            end
        end
        else
        begin
            // no ac signal or silent interval: held high
            ring_detect_full_n_o <= 1'b1;
            ring_detect_half_n_o <= 1'b1;
            phase_q              <= 0;
            half_q               <= 1'b0;
        end
    end
endmodule

//--- verification/tb_hkr_host.sv
`timescale 1ns/1ps
`define TB_CHK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("Error %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module tb_hkr_host
    import hkr_pkg::*;
;
    logic        ref_clk_i;
    logic        rstn_i;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        hook_n;
    logic        ring_n;
    logic        cid_win;
    logic        ring_on;
    logic        rev;
    logic [31:0] v;
    logic        ring_half_n;
    logic        half_prev   = 1'b1;
    logic        full_prev   = 1'b1;
    int          half_falls  = 0;
    int          full_falls  = 0;
    int          num_errors  = 0;
    int          comparisons = 0;

    // short counts keep the run small; expectations follow these values
    hkr_host #(.TRIM_CYC(50), .REV_MIN(4), .REV_MAX(12), .GAP_CYC(40),
        .RING_MIN(4)) dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .hook_control_n_o(hook_n),
        .ring_detect_full_n_i(ring_n), .caller_identity_win_o(cid_win));

    hkr_line_model line (.ref_clk_i(ref_clk_i), .hook_control_n_i(hook_n),
        .ring_on_i(ring_on), .rev_i(rev), .ring_detect_full_n_o(ring_n),
        .ring_detect_half_n_o(ring_half_n));

    // falls of both detect outputs, counted for the pulse-rate checks
    always @(posedge ref_clk_i)
    begin
        half_prev <= ring_half_n;
        full_prev <= ring_n;
        if (half_prev && !ring_half_n)
            half_falls <= half_falls + 1;
        if (full_prev && !ring_n)
            full_falls <= full_falls + 1;
    end

    // 125 MHz
    initial
    begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk_i);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk_i);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wait_pin(input logic val);
        int n;
        n = 0;
        while (hook_n !== val && n < 100)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        #1 `TB_CHK("hook pin", val, hook_n)
        if (hook_n !== val)
            end_sim();
    endtask

    // off-hook request during trim hold waits; ringing ignored off-hook
    task automatic t_hook();
        wr_reg(4'h0, 32'h0000_0001);
        repeat (30)
        begin
            @(posedge ref_clk_i);
            #1 `TB_CHK("trim hold", 1'b1, hook_n)
        end
        wait_pin(1'b0);
        rd_reg(4'h1, v);
        `TB_CHK("status", 2'h3, v[1:0])
        rd_reg(4'h7, v);
        `TB_CHK("unmapped", 32'h0000_0000, v)
        ring_on <= 1'b1;
        repeat (40) @(posedge ref_clk_i);
        ring_on <= 1'b0;
        repeat (60) @(posedge ref_clk_i);
        rd_reg(4'h2, v);
        `TB_CHK("offhook evt", 3'h0, v[2:0])
        wr_reg(4'h0, 32'h0000_0000);
        wait_pin(1'b1);
        $display("test hook done");
    endtask

    // one burst of three ringing cycles, then silence ends it
    task automatic t_ring();
        int h0;
        int f0;
        `TB_CHK("win idle", 1'b0, cid_win)
        @(posedge ref_clk_i);
        h0 = half_falls;
        f0 = full_falls;
        ring_on <= 1'b1;
        repeat (114) @(posedge ref_clk_i);
        ring_on <= 1'b0;
        repeat (70) @(posedge ref_clk_i);
        `TB_CHK("full falls", 32'h0000_0006, full_falls - f0)
        `TB_CHK("half falls", 32'h0000_0003, half_falls - h0)
        rd_reg(4'h2, v);
        `TB_CHK("ring evt", 3'h3, v[2:0])
        rd_reg(4'h3, v);
        `TB_CHK("bursts", 8'h01, v[15:8])
        #1 `TB_CHK("win after", 1'b1, cid_win)
        wr_reg(4'h2, 32'h0000_0007);
        rd_reg(4'h2, v);
        `TB_CHK("evt clear", 3'h0, v[2:0])
        $display("test ring done");
    endtask

    // lone 8-cycle low pulse falls inside the reversal window
    task automatic t_reversal();
        @(posedge ref_clk_i);
        rev <= 1'b1;
        @(posedge ref_clk_i);
        rev <= 1'b0;
        repeat (60) @(posedge ref_clk_i);
        rd_reg(4'h2, v);
        `TB_CHK("rev evt", 3'h4, v[2:0])
        wr_reg(4'h2, 32'h0000_0007);
        $display("test reversal done");
    endtask

    // caller-before-ring mode holds the window open; it is already open after the earlier burst
    task automatic t_early();
        wr_reg(4'h0, 32'h0000_0002);
        repeat (4) @(posedge ref_clk_i);
        #1 `TB_CHK("early win", 1'b1, cid_win)
        `TB_CHK("still on-hook", 1'b1, hook_n)
        wr_reg(4'h0, 32'h0000_0000);
        $display("test early done");
    endtask

    initial
    begin
        rstn_i  = 1'b0;
        addr    = 4'h0;
        wdata   = 32'h0000_0000;
        wr      = 1'b0;
        rd      = 1'b0;
        ring_on = 1'b0;
        rev     = 1'b0;
        repeat (16) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        t_hook();
        t_ring();
        t_reversal();
        t_early();
        end_sim();
    end
endmodule
